// ==== design/rcic_cfg.svh ====
// timing counts and field positions for the reset and clock input control
`ifndef RCIC_CFG_SVH
`define RCIC_CFG_SVH

// oscillator periods per machine cycle
`define RCIC_OSC_PER_MC 12
// external pin must stay high two machine cycles
`define RCIC_EXT_HOLD_OSC 6'h18
// watchdog pin pulse lasts three machine cycles
`define RCIC_WDT_PULSE_OSC 6'h24
// internal hold after a software reset, two machine cycles
`define RCIC_SOFT_HOLD_OSC 6'h18
// soft reset bit position inside the auxiliary control register
`define RCIC_SOFT_RESET_BIT 5
`define RCIC_AUX_WIDTH 8
`define RCIC_CNT_WIDTH 6

`endif

// ==== design/rcic_pkg.sv ====
// types shared by the reset and clock input control
package rcic_pkg;

    typedef enum logic [1:0] {
        RCIC_CAUSE_POWER_ON = 2'b00,
        RCIC_CAUSE_EXT_PIN = 2'b01,
        RCIC_CAUSE_WATCHDOG = 2'b10,
        RCIC_CAUSE_SOFT = 2'b11
    } rcic_cause_t;

    typedef enum logic {
        RCIC_ST_RESET = 1'b0,
        RCIC_ST_RUN = 1'b1
    } rcic_state_t;

endpackage : rcic_pkg

// ==== design/rcic_pulse_timer.sv ====
// retriggerable one-shot that stays busy for a loaded number of cycles
module rcic_pulse_timer #(
    parameter int W = 6
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [W-1:0] length,
    output logic busy
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic busy_r;

    // a new start during a pulse restarts the full length
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = length;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // registered so busy equals cnt_r nonzero without a decode glitch
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (cnt_nxt != '0);
        end
    end

    assign busy = busy_r;

endmodule : rcic_pulse_timer

// ==== design/rcic_reset_ctrl.sv ====
// reset source combining, watchdog pin pulse and divide-by-two clock input
`include "rcic_cfg.svh"

// Summary of operation
// [RULE1] pin high 24 oscillator periods enters reset
// [RULE2] power-on detector asserts reset by itself
// [RULE3] watchdog drives pin high three machine cycles
// [RULE4] watchdog overflow forces internal reset directly
// [RULE5] soft reset bit five causes reset
// [RULE6] internal clock through divide-by-two flop
// [RULE7] external clock drives crystal input only
// [RULE8] fully static, state kept when clock stops
// [RULE9] board holds pin through oscillator start
// [RULE10] power-off flag set on power-up, software writable
// [RULE11] all sources merge into one synchronous reset
module rcic_reset_ctrl #(
    parameter logic [5:0] EXT_HOLD_OSC = `RCIC_EXT_HOLD_OSC,
    parameter logic [5:0] WDT_PULSE_OSC = `RCIC_WDT_PULSE_OSC,
    parameter logic [5:0] SOFT_HOLD_OSC = `RCIC_SOFT_HOLD_OSC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic power_on_detector,
    input wire logic watchdog_enable,
    input wire logic watchdog_counter_ovf,
    input wire logic auxiliary_control_one_wr,
    input wire logic [`RCIC_AUX_WIDTH-1:0] auxiliary_control_one_wdata,
    input wire logic power_off_flag_wr,
    input wire logic power_off_flag_wdata,
    output logic int_clk,
    output logic sys_rst_n,
    output logic power_off_flag,
    output rcic_pkg::rcic_cause_t rst_cause
);
    import rcic_pkg::*;

    logic [`RCIC_CNT_WIDTH-1:0] pin_hi_cnt_r;
    logic [`RCIC_CNT_WIDTH-1:0] pin_hi_cnt_nxt;
    logic ext_rst_r;
    logic int_clk_r;
    logic wdt_start;
    logic wdt_busy;
    logic soft_start;
    logic soft_busy;
    logic rst_req;
    logic power_off_flag_r;
    rcic_state_t state_r;
    rcic_cause_t cause_r;

    // clk_sys is the oscillator taken from the crystal input
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            int_clk_r <= 1'b0;
        end else begin
            int_clk_r <= ~int_clk_r; // [RULE6]
        end
    end

    // any low sample restarts the count, so glitches never reset the chip
    always_comb begin
        pin_hi_cnt_nxt = '0;
        if (rst_pin_in) begin // [RULE9]
            pin_hi_cnt_nxt = (pin_hi_cnt_r == EXT_HOLD_OSC) ? pin_hi_cnt_r
                                                            : pin_hi_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_hi_cnt_r <= '0;
            ext_rst_r <= 1'b0;
        end else begin
            pin_hi_cnt_r <= pin_hi_cnt_nxt;
            ext_rst_r <= (pin_hi_cnt_nxt == EXT_HOLD_OSC); // [RULE1]
        end
    end

    assign wdt_start = watchdog_enable && watchdog_counter_ovf;
    assign soft_start = auxiliary_control_one_wr
                        && auxiliary_control_one_wdata[`RCIC_SOFT_RESET_BIT]; // [RULE5]

    rcic_pulse_timer #(
        .W(`RCIC_CNT_WIDTH)
    ) u_wdt_pulse (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(wdt_start),
        .length(WDT_PULSE_OSC),
        .busy(wdt_busy)
    );

    rcic_pulse_timer #(
        .W(`RCIC_CNT_WIDTH)
    ) u_soft_hold (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(soft_start),
        .length(SOFT_HOLD_OSC),
        .busy(soft_busy)
    );

    // pull-up only: the pin is never driven low from inside
    assign rst_pin_out = 1'b1;
    assign rst_pin_oe_n = ~wdt_busy; // [RULE3]

    // watchdog goes straight in, not via the pin: a strong board pull-down
    // cannot mask it
    assign rst_req = power_on_detector // [RULE2]
                     || wdt_busy // [RULE4]
                     || ext_rst_r
                     || soft_busy;

    // release only ahead of a rising internal clock edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= RCIC_ST_RESET;
        end else begin
            unique case (state_r)
                RCIC_ST_RESET: begin
                    if (!rst_req && int_clk_r) begin // [RULE11]
                        state_r <= RCIC_ST_RUN;
                    end
                end
                RCIC_ST_RUN: begin
                    if (rst_req) begin // [RULE11]
                        state_r <= RCIC_ST_RESET;
                    end
                end
            endcase
        end
    end

    // nothing here decays with time, so a stopped clock loses no state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cause_r <= RCIC_CAUSE_POWER_ON;
        end else if (power_on_detector) begin
            cause_r <= RCIC_CAUSE_POWER_ON;
        end else if (wdt_busy) begin
            cause_r <= RCIC_CAUSE_WATCHDOG;
        end else if (ext_rst_r) begin
            cause_r <= RCIC_CAUSE_EXT_PIN;
        end else if (soft_busy) begin
            cause_r <= RCIC_CAUSE_SOFT; // [RULE8]
        end
    end

    // power-up sets the flag and wins over a software clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_off_flag_r <= 1'b1;
        end else if (power_on_detector) begin
            power_off_flag_r <= 1'b1; // [RULE10]
        end else if (power_off_flag_wr) begin
            power_off_flag_r <= power_off_flag_wdata; // [RULE10]
        end
    end

    assign int_clk = int_clk_r;
    assign sys_rst_n = (state_r == RCIC_ST_RUN);
    assign power_off_flag = power_off_flag_r;
    assign rst_cause = cause_r;

    logic [`RCIC_CNT_WIDTH-1:0] drv_len_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drv_len_r <= '0;
        end else if (rst_pin_oe_n) begin
            drv_len_r <= '0;
        end else begin
            drv_len_r <= drv_len_r + 1'b1;
        end
    end

    AST_EXT_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
        $rose(ext_rst_r) |-> $past(rst_pin_in) && ($past(pin_hi_cnt_r) == (EXT_HOLD_OSC - 6'h01)))
        else $error("external reset taken before 24 high samples");
    AST_EXT_ENTER: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
        ext_rst_r |=> !sys_rst_n)
        else $error("external reset did not hold the core in reset");
    AST_POR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
        power_on_detector |=> !sys_rst_n && (rst_cause == RCIC_CAUSE_POWER_ON))
        else $error("power-on detector did not reset the core");
    AST_WDT_PIN_START: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE3]
        wdt_start |=> !rst_pin_oe_n && rst_pin_out)
        else $error("watchdog pulse did not drive the pin");
    AST_WDT_PIN_LEN: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE3]
        $rose(rst_pin_oe_n) |-> (drv_len_r == WDT_PULSE_OSC))
        else $error("watchdog pin pulse not three machine cycles");
    AST_WDT_INTERNAL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE4]
        wdt_start |=> ##2 (!sys_rst_n)[*8])
        else $error("watchdog overflow did not force internal reset");
    AST_SOFT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
        soft_start && !power_on_detector && !wdt_start |=> ##2 !sys_rst_n
        && (rst_cause == RCIC_CAUSE_SOFT || rst_cause == RCIC_CAUSE_EXT_PIN
            || rst_cause == RCIC_CAUSE_WATCHDOG))
        else $error("soft reset bit did not reset the core");
    AST_DIV2: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE6]
        1'b1 |=> (int_clk != $past(int_clk)))
        else $error("internal clock is not a divide by two");
    AST_STATIC: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE8]
        !rst_req |=> $stable(rst_cause))
        else $error("reset cause changed without a request");
    AST_PWR_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE10]
        (!power_on_detector && !power_off_flag_wr) |=> $stable(power_off_flag))
        else $error("power-off flag changed without a cause");
    AST_PWR_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE10]
        power_on_detector |=> power_off_flag)
        else $error("power-up did not set the power-off flag");
    AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE11]
        $rose(sys_rst_n) |-> $past(int_clk) && !$past(rst_req))
        else $error("reset released off the internal clock phase");

    COV_EXT: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(ext_rst_r));
    COV_WDT: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(rst_pin_oe_n));
    COV_SOFT: cover property (@(posedge clk_sys) disable iff (!arst_n) soft_start ##3 !sys_rst_n);
    COV_PWR_FLAG_CLR: cover property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(power_off_flag));

endmodule : rcic_reset_ctrl

// ==== testbench/rcic_board_model.sv ====
// board side: reset pin network and gated oscillator source
module rcic_board_model (
    input wire logic clk_osc,
    input wire logic clk_run,
    input wire logic board_hold,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    output logic clk_sys,
    output logic rst_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the crystal input is driven; gate changes while clk_osc is low
    assign clk_sys = clk_osc & clk_run;
    // pin pulled down on the board, wired with the device pull-up
    assign rst_pin_in = board_hold | (~rst_pin_oe_n & rst_pin_out);
endmodule : rcic_board_model

// ==== testbench/reset_and_clock_input_control_bench.sv ====
// self-checking bench for the reset and clock input control
`include "rcic_cfg.svh"
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); end end
module reset_and_clock_input_control_bench import rcic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_osc = 0, clk_run = 1, board_hold = 0, arst_n = 0, pwr_on_det = 0;
    logic wd_en = 0, wd_ovf = 0, aux_wr = 0, flag_wr = 0, flag_wdata = 0;
    logic [7:0] aux_wdata = 8'h00;
    logic clk_sys, rst_pin_in, rst_pin_out, rst_pin_oe_n, int_clk, sys_rst_n, power_off_flag;
    rcic_cause_t rst_cause;
    int error_cnt = 0;
    int total_checks = 0;
    always #2.5 clk_osc = ~clk_osc;
    rcic_board_model i_board (.clk_osc(clk_osc), .clk_run(clk_run), .board_hold(board_hold),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .clk_sys(clk_sys),
        .rst_pin_in(rst_pin_in));
    rcic_reset_ctrl i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .power_on_detector(pwr_on_det),
        .watchdog_enable(wd_en), .watchdog_counter_ovf(wd_ovf),
        .auxiliary_control_one_wr(aux_wr), .auxiliary_control_one_wdata(aux_wdata),
        .power_off_flag_wr(flag_wr), .power_off_flag_wdata(flag_wdata), .int_clk(int_clk),
        .sys_rst_n(sys_rst_n), .power_off_flag(power_off_flag), .rst_cause(rst_cause));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_osc);
    endtask : cyc
    task automatic print_verdict;
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // bounded wait for the core reset to lift
    task automatic wait_run;
        for (int i = 0; i < 100 && sys_rst_n !== 1'b1; i++) cyc(1);
        if (sys_rst_n !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_run
    task automatic test_clock;
        logic p;
        p = int_clk;
        cyc(1);
        `CHECK_EQ(int_clk, ~p)
        cyc(1);
        `CHECK_EQ(int_clk, p)
    endtask : test_clock
    task automatic test_pin;
        board_hold = 1;
        cyc(23);
        board_hold = 0;
        cyc(4);
        `CHECK_EQ(sys_rst_n, 1'b1)
        board_hold = 1;
        cyc(int'(`RCIC_EXT_HOLD_OSC));
        `CHECK_EQ(sys_rst_n, 1'b1)
        cyc(1);
        `CHECK_EQ(sys_rst_n, 1'b0)
        `CHECK_EQ(rst_cause, RCIC_CAUSE_EXT_PIN)
        board_hold = 0;
        wait_run();
    endtask : test_pin
    task automatic test_watchdog;
        int n;
        wd_ovf = 1;
        cyc(1);
        wd_ovf = 0;
        cyc(4);
        `CHECK_EQ(rst_pin_oe_n, 1'b1)
        `CHECK_EQ(sys_rst_n, 1'b1)
        wd_en = 1;
        wd_ovf = 1;
        cyc(1);
        wd_ovf = 0;
        n = 0;
        // pin is already driven one edge after the overflow is taken
        for (int i = 0; i < 100; i++) begin
            if (rst_pin_oe_n === 1'b0) n++;
            else if (n > 0) break;
            if (n == 2) begin
                `CHECK_EQ(sys_rst_n, 1'b0)
                `CHECK_EQ(rst_cause, RCIC_CAUSE_WATCHDOG)
                `CHECK_EQ(rst_pin_in, 1'b1)
            end
            cyc(1);
        end
        `CHECK_EQ(n, int'(`RCIC_WDT_PULSE_OSC))
        wd_en = 0;
        wait_run();
    endtask : test_watchdog
    task automatic test_soft;
        aux_wdata = ~(8'h01 << `RCIC_SOFT_RESET_BIT);
        aux_wr = 1;
        cyc(1);
        aux_wr = 0;
        cyc(4);
        `CHECK_EQ(sys_rst_n, 1'b1)
        aux_wdata = 8'h01 << `RCIC_SOFT_RESET_BIT;
        aux_wr = 1;
        cyc(1);
        aux_wr = 0;
        cyc(3);
        `CHECK_EQ(sys_rst_n, 1'b0)
        `CHECK_EQ(rst_cause, RCIC_CAUSE_SOFT)
        wait_run();
    endtask : test_soft
    // clear is held through the power-up cycle: the set must win
    task automatic test_flag;
        flag_wdata = 0;
        flag_wr = 1;
        cyc(1);
        `CHECK_EQ(power_off_flag, 1'b0)
        pwr_on_det = 1;
        cyc(1);
        `CHECK_EQ(sys_rst_n, 1'b0)
        `CHECK_EQ(power_off_flag, 1'b1)
        `CHECK_EQ(rst_cause, RCIC_CAUSE_POWER_ON)
        flag_wr = 0;
        pwr_on_det = 0;
        wait_run();
    endtask : test_flag
    // stopped source must leave int_clk, power_off_flag and sys_rst_n untouched
    task automatic test_stop;
        logic ic;
        flag_wr = 1;
        cyc(1);
        flag_wr = 0;
        clk_run = 0;
        ic = int_clk;
        cyc(20);
        `CHECK_EQ(int_clk, ic)
        `CHECK_EQ(power_off_flag, 1'b0)
        `CHECK_EQ(sys_rst_n, 1'b1)
        clk_run = 1;
        cyc(2);
        `CHECK_EQ(int_clk, ic)
        flag_wdata = 1;
        flag_wr = 1;
        cyc(1);
        flag_wr = 0;
        `CHECK_EQ(power_off_flag, 1'b1)
    endtask : test_stop
    initial begin
        cyc(12);
        `CHECK_EQ(sys_rst_n, 1'b0)
        `CHECK_EQ(power_off_flag, 1'b1)
        arst_n = 1;
        wait_run();
        test_clock();
        test_pin();
        test_watchdog();
        test_soft();
        test_flag();
        test_stop();
        print_verdict();
    end
endmodule : reset_and_clock_input_control_bench
